// ==== rtl/exec_pkg.sv ====
// Shared constants, operation codes and carrier types of the execution block.
package exec_pkg;

  // Widths of the core datapath.
  localparam int unsigned DATA_W = 8;
  localparam int unsigned PC_W = 16;
  localparam int unsigned PTR_W = 16;
  localparam int unsigned OFFSET_W = 7;
  localparam int unsigned DISP_W = 6;

  // Bit positions inside the flag register, and its reset value.
  localparam int unsigned FLAG_C = 0;
  localparam int unsigned FLAG_Z = 1;
  localparam int unsigned FLAG_N = 2;
  localparam int unsigned FLAG_V = 3;
  localparam int unsigned FLAG_S = 4;
  localparam int unsigned FLAG_H = 5;
  localparam int unsigned FLAG_T = 6;
  localparam int unsigned FLAG_I = 7;
  localparam logic [7:0] FLAGS_RESET = 8'h00;

  // Program counter and pointer steps.
  localparam logic [15:0] PC_BRANCH_STEP = 16'h0001;
  localparam logic [15:0] PC_SKIP_ONE = 16'h0002;
  localparam logic [15:0] PC_SKIP_TWO = 16'h0003;
  localparam logic [15:0] PTR_STEP = 16'h0001;

  // Extra clocks spent after the accepting clock.
  localparam logic [1:0] EXTRA_TAKEN = 2'h1;
  localparam logic [1:0] EXTRA_SKIP_ONE = 2'h1;
  localparam logic [1:0] EXTRA_SKIP_TWO = 2'h2;

  // Register port map.
  localparam logic [3:0] REG_FLAGS = 4'h0;
  localparam logic [3:0] REG_TARGET_LO = 4'h1;
  localparam logic [3:0] REG_TARGET_HI = 4'h2;
  localparam logic [3:0] REG_EXEC_CNT = 4'h3;
  localparam logic [7:0] REG_UNMAPPED = 8'h00;

  typedef enum logic [4:0] {
    OP_NONE = 5'h00,
    OP_CMP_BORROW = 5'h01,
    OP_CMP_CONST = 5'h02,
    OP_SKIP_REG_LOW = 5'h03,
    OP_SKIP_REG_HIGH = 5'h04,
    OP_SKIP_IO_LOW = 5'h05,
    OP_SKIP_IO_HIGH = 5'h06,
    OP_BR_FLAG_HIGH = 5'h07,
    OP_BR_FLAG_LOW = 5'h08,
    OP_BR_EQUAL = 5'h09,
    OP_BR_UNEQUAL = 5'h0a,
    OP_BR_CARRY_HIGH = 5'h0b,
    OP_BR_CARRY_LOW = 5'h0c,
    OP_BR_SAME_OR_HIGHER = 5'h0d,
    OP_BR_LOWER_UNSIGNED = 5'h0e,
    OP_BR_NEGATIVE = 5'h0f,
    OP_BR_POSITIVE = 5'h10,
    OP_BR_SIGNED_GE = 5'h11,
    OP_BR_SIGNED_LT = 5'h12,
    OP_BR_HALF_CARRY_HIGH = 5'h13,
    OP_BR_HALF_CARRY_LOW = 5'h14,
    OP_BR_TRANSFER_BIT_HIGH = 5'h15,
    OP_BR_TRANSFER_BIT_LOW = 5'h16,
    OP_BR_OVERFLOW_HIGH = 5'h17,
    OP_BR_IRQ_ON = 5'h18,
    OP_BR_IRQ_OFF = 5'h19,
    OP_LOAD = 5'h1a
  } op_t;

  typedef enum logic [1:0] {
    LD_PLAIN = 2'b00,
    LD_POST_INC = 2'b01,
    LD_PRE_DEC = 2'b10,
    LD_DISP = 2'b11
  } ld_mode_t;

  typedef struct packed {
    op_t op;
    logic [7:0] rd_val;
    logic [7:0] opb;
    logic [7:0] io_val;
    logic [2:0] bit_sel;
    logic [6:0] offset;
    logic [15:0] pc;
    logic next_two_word;
    logic [15:0] ptr_val;
    logic [1:0] ptr_sel;
    ld_mode_t ld_mode;
    logic [5:0] disp;
    logic [4:0] dst_idx;
  } exec_req_t;

  typedef struct packed {
    logic done;
    logic pc_load;
    logic [15:0] pc_target;
    logic rd_we;
    logic [4:0] rd_idx;
    logic [7:0] rd_data;
    logic ptr_we;
    logic [1:0] ptr_sel;
    logic [15:0] ptr_data;
  } exec_rsp_t;

endpackage : exec_pkg

// ==== rtl/cmp_flag_unit.sv ====
// Subtract-and-compare flag generator for the compare operations.
`timescale 1ns/1ps
`default_nettype none

module cmp_flag_unit (
  // Operands
  input wire logic [7:0] a_i,
  input wire logic [7:0] b_i,
  input wire logic borrow_i,
  // Zero chaining
  input wire logic chain_zero_i,
  input wire logic zero_old_i,
  // Flags
  output logic carry_o,
  output logic zero_o,
  output logic neg_o,
  output logic ovf_o,
  output logic half_o
);

  logic [7:0] diff;

  assign diff = a_i - b_i - {7'h00, borrow_i};

  assign half_o = (~a_i[3] & b_i[3]) | (b_i[3] & diff[3]) |
                  (diff[3] & ~a_i[3]);
  assign carry_o = (~a_i[7] & b_i[7]) | (b_i[7] & diff[7]) |
                   (diff[7] & ~a_i[7]);
  assign ovf_o = (a_i[7] & ~b_i[7] & ~diff[7]) |
                 (~a_i[7] & b_i[7] & diff[7]);
  assign neg_o = diff[7];
  // A borrow compare only keeps zero set when the earlier byte was zero too.
  assign zero_o = (diff == 8'h00) & (~chain_zero_i | zero_old_i);

endmodule : cmp_flag_unit

`default_nettype wire

// ==== rtl/cpu_branch_skip_load_exec.sv ====
// Execution unit for compares, skips, flag branches and indirect loads.
//
// Local design decisions: the address map and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none

// Function
// - Compares subtract constant, or register plus carry; update Z,N,V,C,H.
// - Register bit skip advances PC by 2 or 3 on match, flags untouched.
// - I/O bit skip advances PC by 2 or 3 on match, flags untouched.
// - Flag-select branch loads PC plus offset plus one on matching bit.
// - Branches on the Z, C and N flags, each set or clear.
// - Signed branches test negative xor overflow, zero or one.
// - Half-carry branches test the half-carry flag high or low.
// - Transfer-bit branches test the transfer flag high or low.
// - Overflow branch is taken when the overflow flag is one.
// - Interrupt branches test the global interrupt enable flag.
// - Post-increment load reads at pointer, then steps it, two clocks.
// - Pre-decrement load decrements pointer first, then reads, two clocks.
// - Load reads pointer plus displacement, pointer kept, two clocks.
module cpu_branch_skip_load_exec (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // Request from decode
  input wire logic req_valid_i,
  input wire exec_pkg::exec_req_t req_i,
  output logic busy_o,
  // Results to the register file and program counter
  output exec_pkg::exec_rsp_t rsp_o,
  output logic [7:0] flags_o,
  // Data memory read port
  output logic dm_rd_o,
  output logic [15:0] dm_addr_o,
  input wire logic [7:0] dm_rdata_i,
  // Register port
  input wire logic [3:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_we_i,
  input wire logic reg_re_i,
  output logic [7:0] reg_rdata_o
);

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_HOLD = 2'b01,
    ST_LOAD = 2'b10
  } state_t;

  state_t state_q;
  logic busy_q;
  logic [1:0] wait_q;
  logic [7:0] flags_q;
  exec_pkg::exec_rsp_t rsp_q;
  logic [15:0] pend_target_q;
  logic [4:0] pend_idx_q;
  logic [1:0] pend_ptr_sel_q;
  logic [15:0] pend_ptr_q;
  logic pend_ptr_we_q;
  logic dm_rd_q;
  logic [15:0] dm_addr_q;
  logic [15:0] last_target_q;
  logic [7:0] exec_cnt_q;
  logic [7:0] reg_rdata_q;

  logic accept;
  logic is_cmp;
  logic is_skip;
  logic is_branch;
  logic is_load;
  logic cond;
  logic sel_flag;
  logic reg_bit;
  logic io_bit;
  logic [15:0] br_target;
  logic [15:0] skip_target;
  logic [15:0] ld_addr;
  logic [15:0] ptr_next;
  logic ptr_changes;
  logic cf_c;
  logic cf_z;
  logic cf_n;
  logic cf_v;
  logic cf_h;

  assign accept = req_valid_i & ~busy_q;

  assign is_cmp = (req_i.op == exec_pkg::OP_CMP_BORROW) |
                  (req_i.op == exec_pkg::OP_CMP_CONST);
  assign is_skip = (req_i.op == exec_pkg::OP_SKIP_REG_LOW) |
                   (req_i.op == exec_pkg::OP_SKIP_REG_HIGH) |
                   (req_i.op == exec_pkg::OP_SKIP_IO_LOW) |
                   (req_i.op == exec_pkg::OP_SKIP_IO_HIGH);
  assign is_load = (req_i.op == exec_pkg::OP_LOAD);
  assign is_branch = (req_i.op >= exec_pkg::OP_BR_FLAG_HIGH) &
                     (req_i.op <= exec_pkg::OP_BR_IRQ_OFF);

  assign sel_flag = flags_q[req_i.bit_sel];
  assign reg_bit = req_i.rd_val[req_i.bit_sel];
  assign io_bit = req_i.io_val[req_i.bit_sel];

  // The compare borrows the stored carry only for the register form.
  cmp_flag_unit cmp_flag_unit_inst (
    .a_i(req_i.rd_val),
    .b_i(req_i.opb),
    .borrow_i((req_i.op == exec_pkg::OP_CMP_BORROW) &
              flags_q[exec_pkg::FLAG_C]),
    .chain_zero_i(req_i.op == exec_pkg::OP_CMP_BORROW),
    .zero_old_i(flags_q[exec_pkg::FLAG_Z]),
    .carry_o(cf_c),
    .zero_o(cf_z),
    .neg_o(cf_n),
    .ovf_o(cf_v),
    .half_o(cf_h)
  );

  // Condition of every skip and branch: skips test the request bit, branches the stored flags.
  always_comb begin
    cond = 1'b0;
    unique case (req_i.op)
      exec_pkg::OP_SKIP_REG_LOW: cond = ~reg_bit;
      exec_pkg::OP_SKIP_REG_HIGH: cond = reg_bit;
      exec_pkg::OP_SKIP_IO_LOW: cond = ~io_bit;
      exec_pkg::OP_SKIP_IO_HIGH: cond = io_bit;
      exec_pkg::OP_BR_FLAG_HIGH: cond = sel_flag;
      exec_pkg::OP_BR_FLAG_LOW: cond = ~sel_flag;
      exec_pkg::OP_BR_EQUAL: cond = flags_q[exec_pkg::FLAG_Z];
      exec_pkg::OP_BR_UNEQUAL: cond = ~flags_q[exec_pkg::FLAG_Z];
      exec_pkg::OP_BR_CARRY_HIGH: cond = flags_q[exec_pkg::FLAG_C];
      exec_pkg::OP_BR_CARRY_LOW: cond = ~flags_q[exec_pkg::FLAG_C];
      exec_pkg::OP_BR_SAME_OR_HIGHER: begin
        cond = ~flags_q[exec_pkg::FLAG_C];
      end
      exec_pkg::OP_BR_LOWER_UNSIGNED: begin
        cond = flags_q[exec_pkg::FLAG_C];
      end
      exec_pkg::OP_BR_NEGATIVE: cond = flags_q[exec_pkg::FLAG_N];
      exec_pkg::OP_BR_POSITIVE: cond = ~flags_q[exec_pkg::FLAG_N];
      exec_pkg::OP_BR_SIGNED_GE: begin
        cond = ~(flags_q[exec_pkg::FLAG_N] ^ flags_q[exec_pkg::FLAG_V]);
      end
      exec_pkg::OP_BR_SIGNED_LT: begin
        cond = flags_q[exec_pkg::FLAG_N] ^ flags_q[exec_pkg::FLAG_V];
      end
      exec_pkg::OP_BR_HALF_CARRY_HIGH: begin
        cond = flags_q[exec_pkg::FLAG_H];
      end
      exec_pkg::OP_BR_HALF_CARRY_LOW: begin
        cond = ~flags_q[exec_pkg::FLAG_H];
      end
      exec_pkg::OP_BR_TRANSFER_BIT_HIGH: begin
        cond = flags_q[exec_pkg::FLAG_T];
      end
      exec_pkg::OP_BR_TRANSFER_BIT_LOW: begin
        cond = ~flags_q[exec_pkg::FLAG_T];
      end
      exec_pkg::OP_BR_OVERFLOW_HIGH: begin
        cond = flags_q[exec_pkg::FLAG_V];
      end
      exec_pkg::OP_BR_IRQ_ON: cond = flags_q[exec_pkg::FLAG_I];
      exec_pkg::OP_BR_IRQ_OFF: cond = ~flags_q[exec_pkg::FLAG_I];
      default: cond = 1'b0;
    endcase
  end

  // The signed offset counts from the word after the branch.
  assign br_target = req_i.pc + {{9{req_i.offset[6]}}, req_i.offset} +
                     exec_pkg::PC_BRANCH_STEP;
  assign skip_target = req_i.pc + (req_i.next_two_word ?
                       exec_pkg::PC_SKIP_TWO : exec_pkg::PC_SKIP_ONE);

  // Address and pointer write-back for each load form.
  always_comb begin
    ld_addr = req_i.ptr_val;
    ptr_next = req_i.ptr_val;
    ptr_changes = 1'b0;
    unique case (req_i.ld_mode)
      exec_pkg::LD_PLAIN: begin
        ld_addr = req_i.ptr_val;
      end
      exec_pkg::LD_POST_INC: begin
        ld_addr = req_i.ptr_val;
        ptr_next = req_i.ptr_val + exec_pkg::PTR_STEP;
        ptr_changes = 1'b1;
      end
      exec_pkg::LD_PRE_DEC: begin
        ptr_next = req_i.ptr_val - exec_pkg::PTR_STEP;
        ld_addr = ptr_next;
        ptr_changes = 1'b1;
      end
      exec_pkg::LD_DISP: begin
        ld_addr = req_i.ptr_val + {10'h000, req_i.disp};
      end
    endcase
  end

  // Sequencer: holds the block busy for the extra clocks of an operation.
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      state_q <= ST_IDLE;
      busy_q <= 1'b0;
      wait_q <= 2'h0;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          if (accept && is_load) begin
            state_q <= ST_LOAD;
            busy_q <= 1'b1;
          end else if (accept && is_branch && cond) begin
            state_q <= ST_HOLD;
            busy_q <= 1'b1;
            wait_q <= exec_pkg::EXTRA_TAKEN - 2'h1;
          end else if (accept && is_skip && cond) begin
            state_q <= ST_HOLD;
            busy_q <= 1'b1;
            wait_q <= (req_i.next_two_word ? exec_pkg::EXTRA_SKIP_TWO :
                       exec_pkg::EXTRA_SKIP_ONE) - 2'h1;
          end
        end
        ST_HOLD: begin
          if (wait_q == 2'h0) begin
            state_q <= ST_IDLE;
            busy_q <= 1'b0;
          end else begin
            wait_q <= wait_q - 2'h1;
          end
        end
        ST_LOAD: begin
          state_q <= ST_IDLE;
          busy_q <= 1'b0;
        end
        default: begin
          state_q <= ST_IDLE;
          busy_q <= 1'b0;
        end
      endcase
    end
  end

  // Values kept for the final clock of a multi-clock operation.
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      pend_target_q <= 16'h0000;
      pend_idx_q <= 5'h00;
      pend_ptr_sel_q <= 2'h0;
      pend_ptr_q <= 16'h0000;
      pend_ptr_we_q <= 1'b0;
    end else if (accept) begin
      pend_target_q <= is_skip ? skip_target : br_target;
      pend_idx_q <= req_i.dst_idx;
      pend_ptr_sel_q <= req_i.ptr_sel;
      pend_ptr_q <= ptr_next;
      pend_ptr_we_q <= ptr_changes;
    end
  end

  // Data memory read is issued in the clock after the accepting clock.
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      dm_rd_q <= 1'b0;
      dm_addr_q <= 16'h0000;
    end else begin
      dm_rd_q <= accept & is_load;
      if (accept && is_load) begin
        dm_addr_q <= ld_addr;
      end
    end
  end

  // Completion strobes and write-back data.
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      rsp_q <= '0;
    end else begin
      rsp_q.done <= 1'b0;
      rsp_q.pc_load <= 1'b0;
      rsp_q.rd_we <= 1'b0;
      rsp_q.ptr_we <= 1'b0;
      unique case (state_q)
        ST_IDLE: begin
          if (accept && !is_load && !((is_branch || is_skip) && cond)) begin
            rsp_q.done <= 1'b1;
          end
        end
        ST_HOLD: begin
          if (wait_q == 2'h0) begin
            rsp_q.done <= 1'b1;
            rsp_q.pc_load <= 1'b1;
            rsp_q.pc_target <= pend_target_q;
          end
        end
        ST_LOAD: begin
          rsp_q.done <= 1'b1;
          rsp_q.rd_we <= 1'b1;
          rsp_q.rd_idx <= pend_idx_q;
          rsp_q.rd_data <= dm_rdata_i;
          rsp_q.ptr_we <= pend_ptr_we_q;
          rsp_q.ptr_sel <= pend_ptr_sel_q;
          rsp_q.ptr_data <= pend_ptr_q;
        end
        default: begin
          rsp_q.done <= 1'b0;
        end
      endcase
    end
  end

  // Flag register: a compare wins over a port write in the same clock.
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      flags_q <= exec_pkg::FLAGS_RESET;
    end else if (accept && is_cmp) begin
      flags_q[exec_pkg::FLAG_C] <= cf_c;
      flags_q[exec_pkg::FLAG_Z] <= cf_z;
      flags_q[exec_pkg::FLAG_N] <= cf_n;
      flags_q[exec_pkg::FLAG_V] <= cf_v;
      flags_q[exec_pkg::FLAG_H] <= cf_h;
    end else if (reg_we_i && reg_addr_i == exec_pkg::REG_FLAGS) begin
      flags_q <= reg_wdata_i;
    end
  end

  // Trace of the last redirect and a count of completed operations.
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      last_target_q <= 16'h0000;
      exec_cnt_q <= 8'h00;
    end else begin
      if (state_q == ST_HOLD && wait_q == 2'h0) begin
        last_target_q <= pend_target_q;
      end
      if (reg_we_i && reg_addr_i == exec_pkg::REG_EXEC_CNT) begin
        exec_cnt_q <= 8'h00;
      end else if (rsp_q.done) begin
        exec_cnt_q <= exec_cnt_q + 8'h01;
      end
    end
  end

  // Read data stand for one clock after the read strobe.
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      reg_rdata_q <= 8'h00;
    end else if (reg_re_i) begin
      unique case (reg_addr_i)
        exec_pkg::REG_FLAGS: reg_rdata_q <= flags_q;
        exec_pkg::REG_TARGET_LO: reg_rdata_q <= last_target_q[7:0];
        exec_pkg::REG_TARGET_HI: reg_rdata_q <= last_target_q[15:8];
        exec_pkg::REG_EXEC_CNT: reg_rdata_q <= exec_cnt_q;
        default: reg_rdata_q <= exec_pkg::REG_UNMAPPED;
      endcase
    end else begin
      reg_rdata_q <= 8'h00;
    end
  end

  assign busy_o = busy_q;
  assign rsp_o = rsp_q;
  assign flags_o = flags_q;
  assign dm_rd_o = dm_rd_q;
  assign dm_addr_o = dm_addr_q;
  assign reg_rdata_o = reg_rdata_q;

endmodule : cpu_branch_skip_load_exec

`default_nettype wire

// ==== dv/exec_checker_assertions.sv ====
// Concurrent port checks for the execution block.
`timescale 1ns/1ps
`default_nettype none

module exec_checker (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // Request side
  input wire logic req_valid_i,
  input wire exec_pkg::exec_req_t req_i,
  input wire logic busy_o,
  input wire logic reg_we_i,
  // Result side
  input wire exec_pkg::exec_rsp_t rsp_o,
  input wire logic [7:0] flags_o,
  input wire logic dm_rd_o,
  input wire logic [15:0] dm_addr_o,
  input wire logic [7:0] dm_rdata_i
);
  default clocking @(posedge sys_clk_i);
  endclocking
  default disable iff (rst_i);

  logic take;
  logic is_br;
  logic is_cmp;
  logic is_ld;
  logic [15:0] tgt_d;
  logic [15:0] tgt_q;

  assign take = req_valid_i && !busy_o;
  assign is_br = req_i.op >= exec_pkg::OP_BR_FLAG_HIGH &&
                 req_i.op <= exec_pkg::OP_BR_IRQ_OFF;
  assign is_cmp = req_i.op == exec_pkg::OP_CMP_BORROW ||
                  req_i.op == exec_pkg::OP_CMP_CONST;
  assign is_ld = req_i.op == exec_pkg::OP_LOAD;
  assign tgt_d = is_br ?
    req_i.pc + {{9{req_i.offset[6]}}, req_i.offset} + 16'h0001 :
    req_i.pc + (req_i.next_two_word ? 16'h0003 : 16'h0002);

  // Expected program counter target of the operation in flight.
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      tgt_q <= 16'h0000;
    end else if (take) begin
      tgt_q <= tgt_d;
    end
  end

  AST_CMP_ONE: assert property (
    take && is_cmp |=> rsp_o.done && !busy_o && !rsp_o.rd_we)
    else $error("compare did not finish alone in one clock");
  AST_CMP_KEEP: assert property (
    take && is_cmp |=> flags_o[7:6] == $past(flags_o[7:6]) &&
      flags_o[4] == $past(flags_o[4]))
    else $error("compare touched I, T or S");
  AST_NO_FLAGS: assert property (
    take && req_i.op >= exec_pkg::OP_SKIP_REG_LOW && !reg_we_i |=>
      $stable(flags_o))
    else $error("flags changed on skip, branch or load");
  AST_BR_UNTAKEN: assert property (
    take && req_i.op == exec_pkg::OP_BR_EQUAL && !flags_o[1] |=>
      rsp_o.done && !rsp_o.pc_load)
    else $error("equal branch taken with zero clear");
  AST_BR_TAKEN: assert property (
    take && req_i.op == exec_pkg::OP_BR_SIGNED_LT &&
      (flags_o[2] ^ flags_o[3]) |=> busy_o && !rsp_o.done ##1
      rsp_o.done && rsp_o.pc_load && !busy_o)
    else $error("signed less-than branch not taken in two clocks");
  AST_TARGET: assert property (
    rsp_o.pc_load |-> rsp_o.pc_target == tgt_q)
    else $error("wrong program counter target");
  AST_SKIP_TWO: assert property (
    take && req_i.op == exec_pkg::OP_SKIP_REG_HIGH &&
      req_i.rd_val[req_i.bit_sel] && req_i.next_two_word |=>
      busy_o[*2] ##1 rsp_o.done)
    else $error("two-word skip not three clocks");
  AST_SKIP_IO_NONE: assert property (
    take && req_i.op == exec_pkg::OP_SKIP_IO_LOW &&
      req_i.io_val[req_i.bit_sel] |=> rsp_o.done && !rsp_o.pc_load)
    else $error("io skip taken on set bit");
  AST_LOAD_PRE: assert property (
    take && is_ld && req_i.ld_mode == exec_pkg::LD_PRE_DEC |=>
      dm_rd_o && dm_addr_o == $past(req_i.ptr_val) - 16'h0001)
    else $error("pre-decrement load read wrong address");
  AST_LOAD_DATA: assert property (
    dm_rd_o |=> rsp_o.done && rsp_o.rd_we &&
      rsp_o.rd_data == $past(dm_rdata_i))
    else $error("load data not delivered");
  AST_LOAD_POST: assert property (
    take && is_ld && req_i.ld_mode == exec_pkg::LD_POST_INC |-> ##2
      rsp_o.ptr_we &&
      rsp_o.ptr_data == $past(req_i.ptr_val, 2) + 16'h0001)
    else $error("post-increment pointer wrong");
  AST_LOAD_DISP: assert property (
    take && is_ld && req_i.ld_mode == exec_pkg::LD_DISP |=>
      dm_addr_o == $past(req_i.ptr_val) + 16'($past(req_i.disp)) ##1
      !rsp_o.ptr_we)
    else $error("displacement load wrong");
endmodule : exec_checker

bind cpu_branch_skip_load_exec exec_checker exec_checker_inst (
  .sys_clk_i(sys_clk_i),
  .rst_i(rst_i),
  .req_valid_i(req_valid_i),
  .req_i(req_i),
  .busy_o(busy_o),
  .reg_we_i(reg_we_i),
  .rsp_o(rsp_o),
  .flags_o(flags_o),
  .dm_rd_o(dm_rd_o),
  .dm_addr_o(dm_addr_o),
  .dm_rdata_i(dm_rdata_i)
);

`default_nettype wire

// ==== dv/cpu_branch_skip_load_exec_bench.sv ====
// Self-checking bench for the execution block.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin \
  tests_run++; \
  if ((g) !== (e)) begin \
    miscompares++; \
    $display("mismatch %s exp %h got %h", nm, e, g); \
  end \
end

module cpu_branch_skip_load_exec_bench;
  logic sys_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic req_valid_i = 1'b0;
  exec_pkg::exec_req_t req_i = '0;
  logic busy_o;
  exec_pkg::exec_rsp_t rsp_o;
  logic [7:0] flags_o;
  logic dm_rd_o;
  logic [15:0] dm_addr_o;
  logic [7:0] dm_rdata_i;
  logic [3:0] reg_addr_i = 4'h0;
  logic [7:0] reg_wdata_i = 8'h00;
  logic reg_we_i = 1'b0;
  logic reg_re_i = 1'b0;
  logic [7:0] reg_rdata_o;
  int miscompares = 0;
  int tests_run = 0;
  int clocks;
  exec_pkg::exec_rsp_t sr;
  logic [15:0] sa;

  cpu_branch_skip_load_exec cpu_branch_skip_load_exec_inst (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .req_valid_i(req_valid_i),
    .req_i(req_i), .busy_o(busy_o), .rsp_o(rsp_o), .flags_o(flags_o),
    .dm_rd_o(dm_rd_o), .dm_addr_o(dm_addr_o), .dm_rdata_i(dm_rdata_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_we_i(reg_we_i), .reg_re_i(reg_re_i), .reg_rdata_o(reg_rdata_o));

  always #2.5 sys_clk_i = ~sys_clk_i;

  function automatic logic [7:0] mem_val(input logic [15:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h5a;
  endfunction : mem_val

  // Memory answers in the read cycle and shows other data otherwise.
  assign dm_rdata_i = dm_rd_o ? mem_val(dm_addr_o) : ~mem_val(dm_addr_o);

  function automatic logic [7:0] cmp_flags(input logic [7:0] f, a, b,
                                           input logic c);
    logic [8:0] r;
    logic [4:0] h;
    logic [7:0] o;
    r = {1'b0, a} - {1'b0, b} - 9'(c & f[0]);
    h = {1'b0, a[3:0]} - {1'b0, b[3:0]} - 5'(c & f[0]);
    o = f;
    o[0] = r[8];
    o[1] = (r[7:0] == 8'h00) && (!c || f[1]);
    o[2] = r[7];
    o[3] = (a[7] & ~b[7] & ~r[7]) | (~a[7] & b[7] & r[7]);
    o[5] = h[4];
    return o;
  endfunction : cmp_flags

  function automatic logic taken(input exec_pkg::op_t op,
                                 input logic [7:0] f, input logic [2:0] s);
    case (op)
      exec_pkg::OP_BR_FLAG_HIGH: return f[s];
      exec_pkg::OP_BR_FLAG_LOW: return !f[s];
      exec_pkg::OP_BR_EQUAL: return f[1];
      exec_pkg::OP_BR_UNEQUAL: return !f[1];
      exec_pkg::OP_BR_CARRY_HIGH, exec_pkg::OP_BR_LOWER_UNSIGNED: return f[0];
      exec_pkg::OP_BR_CARRY_LOW, exec_pkg::OP_BR_SAME_OR_HIGHER: return !f[0];
      exec_pkg::OP_BR_NEGATIVE: return f[2];
      exec_pkg::OP_BR_POSITIVE: return !f[2];
      exec_pkg::OP_BR_SIGNED_GE: return !(f[2] ^ f[3]);
      exec_pkg::OP_BR_SIGNED_LT: return f[2] ^ f[3];
      exec_pkg::OP_BR_HALF_CARRY_HIGH: return f[5];
      exec_pkg::OP_BR_HALF_CARRY_LOW: return !f[5];
      exec_pkg::OP_BR_TRANSFER_BIT_HIGH: return f[6];
      exec_pkg::OP_BR_TRANSFER_BIT_LOW: return !f[6];
      exec_pkg::OP_BR_OVERFLOW_HIGH: return f[3];
      exec_pkg::OP_BR_IRQ_ON: return f[7];
      default: return !f[7];
    endcase
  endfunction : taken

  task reg_wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_we_i <= 1'b1;
    @(posedge sys_clk_i);
    reg_we_i <= 1'b0;
  endtask : reg_wr

  task reg_rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge sys_clk_i);
    reg_addr_i <= a;
    reg_re_i <= 1'b1;
    @(posedge sys_clk_i);
    reg_re_i <= 1'b0;
    #1 d = reg_rdata_o;
  endtask : reg_rd

  // Issues one request and counts clocks up to its done pulse.
  task run(input exec_pkg::exec_req_t r);
    @(posedge sys_clk_i);
    req_i <= r;
    req_valid_i <= 1'b1;
    clocks = 0;
    sa = 16'hxxxx;
    do begin
      @(posedge sys_clk_i);
      req_valid_i <= 1'b0;
      #1 clocks++;
      if (dm_rd_o === 1'b1) sa = dm_addr_o;
    end while (rsp_o.done !== 1'b1 && clocks < 8);
    sr = rsp_o;
  endtask : run

  task close_out;
    if (miscompares == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : close_out

  initial begin
    repeat (20000) @(posedge sys_clk_i);
    miscompares++;
    close_out();
  end

  initial begin
    exec_pkg::exec_req_t r;
    logic [7:0] d;
    logic [7:0] v;
    logic [7:0] fl;
    logic t;
    logic [15:0] e;
    logic [7:0] fv [4] = '{8'h00, 8'hff, 8'h04, 8'h08};
    logic [7:0] ca [6] = '{8'h10, 8'h80, 8'h3b, 8'h3b, 8'h3b, 8'h00};
    logic [7:0] cb [6] = '{8'h20, 8'h01, 8'h3b, 8'h3a, 8'h3a, 8'h00};
    logic [7:0] cf [6] = '{8'h00, 8'h00, 8'hff, 8'h03, 8'h01, 8'h01};
    logic [15:0] lp [4] = '{16'hffff, 16'h0000, 16'h1234, 16'h0040};
    logic [15:0] la [4] = '{16'hffff, 16'hffff, 16'h1273, 16'h0040};
    logic [15:0] lw [2] = '{16'h0000, 16'hffff};
    repeat (12) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    @(posedge sys_clk_i);
    #1 `CHK("reset", '0, {busy_o, rsp_o, flags_o, dm_rd_o, dm_addr_o})
    for (int a = 0; a < 16; a = a + 3) begin
      reg_rd(4'(a), d);
      `CHK("reg reset", 8'h00, d)
    end
    for (int i = 0; i < 6; i++) begin
      reg_wr(exec_pkg::REG_FLAGS, cf[i]);
      r = '0;
      r.op = i < 3 ? exec_pkg::OP_CMP_CONST : exec_pkg::OP_CMP_BORROW;
      r.rd_val = ca[i];
      r.opb = cb[i];
      run(r);
      `CHK("cmp clocks", 1, clocks)
      `CHK("cmp store", 1'b0, sr.rd_we)
      `CHK("cmp flags", cmp_flags(cf[i], ca[i], cb[i], i >= 3), flags_o)
    end
    for (int i = 7; i <= 25; i++) begin
      for (int j = 0; j < 4; j++) begin
        fl = fv[j];
        reg_wr(exec_pkg::REG_FLAGS, fl);
        r = '0;
        r.op = exec_pkg::op_t'(5'(i));
        r.bit_sel = 3'(i + j);
        r.pc = 16'h1000;
        r.offset = j[0] ? 7'h40 : 7'h3f;
        t = taken(r.op, fl, r.bit_sel);
        e = 16'h1001 + {{9{r.offset[6]}}, r.offset};
        run(r);
        `CHK("br clocks", t ? 2 : 1, clocks)
        `CHK("br load", t, sr.pc_load)
        if (t) `CHK("br target", e, sr.pc_target)
        `CHK("br flags", fl, flags_o)
      end
    end
    for (int i = 3; i <= 6; i++) begin
      for (int j = 0; j < 4; j++) begin
        r = '0;
        r.op = exec_pkg::op_t'(5'(i));
        r.bit_sel = 3'(i * 3 + j);
        r.pc = 16'hfffe;
        r.next_two_word = j[1];
        d = 8'h01 << r.bit_sel;
        v = j[0] ? d : ~d;
        r.rd_val = i < 5 ? v : ~v;
        r.io_val = ~r.rd_val;
        t = (i == 4 || i == 6) == j[0];
        e = 16'hfffe + 16'(2 + j[1]);
        run(r);
        `CHK("skip clocks", t ? 2 + j[1] : 1, clocks)
        `CHK("skip load", t, sr.pc_load)
        if (t) `CHK("skip target", e, sr.pc_target)
        `CHK("skip flags", fl, flags_o)
      end
    end
    reg_wr(exec_pkg::REG_TARGET_LO, 8'hff);
    reg_rd(exec_pkg::REG_TARGET_LO, d);
    `CHK("target lo", 8'h01, d)
    reg_rd(exec_pkg::REG_TARGET_HI, d);
    `CHK("target hi", 8'h00, d)
    reg_wr(exec_pkg::REG_EXEC_CNT, 8'h00);
    for (int k = 0; k < 4; k++) begin
      r = '0;
      r.op = exec_pkg::OP_LOAD;
      r.ld_mode = exec_pkg::ld_mode_t'(2'(k + 1));
      r.ptr_val = lp[k];
      r.ptr_sel = 2'(k);
      r.disp = 6'h3f;
      r.dst_idx = 5'(k + 28);
      run(r);
      `CHK("ld clocks", 2, clocks)
      `CHK("ld addr", la[k], sa)
      `CHK("ld data", mem_val(la[k]), sr.rd_data)
      `CHK("ld dest", {1'b1, 5'(k + 28)}, {sr.rd_we, sr.rd_idx})
      `CHK("ld ptr", k < 2, sr.ptr_we)
      if (k < 2) begin
        `CHK("ld ptr sel", 2'(k), sr.ptr_sel)
        `CHK("ld ptr val", lw[k], sr.ptr_data)
      end
      `CHK("ld flags", fl, flags_o)
    end
    reg_rd(exec_pkg::REG_EXEC_CNT, d);
    `CHK("count", 8'h04, d)
    close_out();
  end
endmodule : cpu_branch_skip_load_exec_bench

`default_nettype wire
